// ### rtl/ppc_pkg.sv
// Package for the port pin control block: widths, reset values, clock source codes
`default_nettype none

package ppc_pkg;
  // ******************************************************
  // Widths
  // ******************************************************
  localparam int A_W = 4;
  localparam int C_W = 8;
  // ******************************************************
  // Reset values
  // ******************************************************
  localparam logic [3:0] A_DIR_RST = 4'hF;
  localparam logic [7:0] C_DIR_RST = 8'hFF;
  localparam logic [3:0] A_DATA_RST = 4'h0;
  localparam logic [7:0] C_DATA_RST = 8'h00;
  localparam logic [3:0] A_PU_RST = 4'h0;
  localparam logic [7:0] C_PU_RST = 8'h00;
  localparam logic B_DIR_RST = 1'h1;
  localparam logic B_DATA_RST = 1'h0;
  localparam logic B_PU_RST = 1'h0;
  // ******************************************************
  // Bit positions of the oscillator-shared pins
  // ******************************************************
  localparam int A_OSC_OUT_BIT = 2;
  localparam int A_OSC_IN_BIT = 3;
  // Port B bit positions in the shared write and readback byte
  localparam int B_PIN_BIT = 2;
  localparam int B_RO_BIT = 4;
  // Port A pins left to the port for each clock source
  localparam logic [3:0] A_OK_ALL = 4'hF;
  localparam logic [3:0] A_OK_XTAL = 4'h3;
  localparam logic [3:0] A_OK_EXT = 4'h7;
  // Clock source codes held in the option byte field
  localparam logic [1:0] CLK_SRC_INT = 2'h0;
  localparam logic [1:0] CLK_SRC_XTAL = 2'h1;
  localparam logic [1:0] CLK_SRC_EXT = 2'h2;
  // Option byte field positions
  localparam int OPT_CLK_LSB = 0;
  localparam int OPT_CLK_W = 2;
  localparam int OPT_RST_PORT_BIT = 2;

  typedef enum logic [1:0] {
    PPC_SRC_INT,
    PPC_SRC_XTAL,
    PPC_SRC_EXT
  } ppc_clk_src_t;

  // Software control word for the three ports
  typedef struct packed {
    logic [3:0] a_dir;
    logic [3:0] a_pu;
    logic [3:0] a_data;
    logic b_dir;
    logic b_pu;
    logic b_data;
    logic [7:0] c_dir;
    logic [7:0] c_pu;
    logic [7:0] c_data;
  } ppc_ctrl_t;

  // Pad drive bundle per port
  typedef struct packed {
    logic [3:0] a_out;
    logic [3:0] a_oe;
    logic [3:0] a_pu;
    logic [3:0] a_pd;
    logic b_out;
    logic b_oe;
    logic b_pu;
    logic [7:0] c_out;
    logic [7:0] c_oe;
    logic [7:0] c_pu;
  } ppc_pad_t;
endpackage : ppc_pkg

`default_nettype wire

// ### rtl/ppc_port_pin_control.sv
// Port pin control: three general-purpose ports with oscillator and reset sharing
// Summary of operation
// R1 - Four-bit port A has a per-bit output latch.
// R2 - Each port A pin has its own direction bit.
// R3 - Port A input pin gets pull-up only when its pull-up bit is set.
// R4 - Internal oscillator selected: both shared pins are ordinary I/O.
// R5 - Crystal selected: both shared pins belong to the oscillator.
// R6 - External clock: upper shared pin is clock input, lower stays I/O.
// R7 - Clock source comes from the option byte, not a run-time register.
// R8 - Any reset makes every port A pin an input.
// R9 - During reset both shared pins are pulled low.
// R10 - Port B interrupt pin has direction and pull-up controls.
// R11 - Port C eight pins have per-pin direction and pull-up.
// R12 - Fourteen pins: thirteen bidirectional, one input-only; thirteen pull-ups.
// R13 - Pins pass alternate functions: timer input, timer output, interrupt.
// R14 - Input-only pin serves as port only when option byte selects it.
// R15 - Data read returns pin level in input, latch value in output.
// R16 - Direction bit zero drives the pin, one makes it an input.
// R17 - Reset clears output latches; input-only pin read is undefined.
// R18 - Pull-up is off whenever the pin is an output.
// R19 - Driver shows the latch one cycle after a data write.
`timescale 1ns/10ps
`default_nettype none

module ppc_port_pin_control (
  input wire logic mclk_i,                 // System clock, 50 MHz
  input wire logic rst_b_i,                // Synchronous reset, active low
  input wire logic [7:0] option_byte_i,    // Nonvolatile option byte
  input wire logic wr_a_dir_i,             // Write strobe, port A direction
  input wire logic wr_a_pu_i,              // Write strobe, port A pull-up enable
  input wire logic wr_a_data_i,            // Write strobe, port A data
  input wire logic wr_b_dir_i,             // Write strobe, port B direction
  input wire logic wr_b_pu_i,              // Write strobe, port B pull-up enable
  input wire logic wr_b_data_i,            // Write strobe, port B data
  input wire logic wr_c_dir_i,             // Write strobe, port C direction
  input wire logic wr_c_pu_i,              // Write strobe, port C pull-up enable
  input wire logic wr_c_data_i,            // Write strobe, port C data
  input wire logic [7:0] wdata_i,          // Write data, low bits used by ports A and B, all eight by port C
  input wire logic [3:0] port_a_pins_i,    // Port A pad levels
  input wire logic port_b_irq_pin_i,       // Port B interrupt pin level
  input wire logic port_b_input_only_pin_i, // Input-only / reset pin level
  input wire logic [7:0] port_c_pins_i,    // Port C pad levels
  input wire logic [1:0] alt_a_oe_i,       // Timer outputs claim pin0/pin1
  input wire logic [1:0] alt_a_out_i,      // Timer output levels for pin0/pin1
  output logic [3:0] port_a_data_o,        // Port A data readback
  output logic [3:0] port_a_direction_o,   // Port A direction readback
  output logic [3:0] port_a_pullup_enable_o, // Port A pull-up readback
  output logic [7:0] port_b_data_o,        // Port B data readback
  output logic [7:0] port_c_data_o,        // Port C data readback
  output logic [3:0] port_a_out_o,         // Port A pad output value
  output logic [3:0] port_a_oe_o,          // Port A pad output enable
  output logic [3:0] port_a_pu_o,          // Port A pull-up on
  output logic [3:0] port_a_pd_o,          // Port A pull-down on
  output logic port_b_irq_out_o,           // Port B pad output value
  output logic port_b_irq_oe_o,            // Port B pad output enable
  output logic port_b_irq_pu_o,            // Port B pull-up on
  output logic [7:0] port_c_out_o,         // Port C pad output value
  output logic [7:0] port_c_oe_o,          // Port C pad output enable
  output logic [7:0] port_c_pu_o,          // Port C pull-up on
  output logic osc_enable_o,               // Crystal oscillator amplifier on
  output logic oscillator_input_pin_o,     // Synchronised external clock level
  output logic timer0_capture_input_o,     // Synchronised pin0 for timer capture
  output logic timer0_second_input_o,      // Synchronised pin1 for timer
  output logic external_irq0_o,            // Synchronised pin1 interrupt level
  output logic external_irq1_o,            // Synchronised port B interrupt level
  output logic reset_pin_is_port_o         // Input-only pin works as port
);

  // ******************************************************
  // Input synchronisers
  // ******************************************************
  localparam int SYN_W = 14;
  logic [SYN_W-1:0] syn1_reg, syn1_next, syn2_reg, syn2_next;

  always_comb begin
    syn1_next = {port_c_pins_i, port_b_input_only_pin_i, port_b_irq_pin_i, port_a_pins_i};
    syn2_next = syn1_reg;
  end

  always_ff @(posedge mclk_i) begin
    syn1_reg <= syn1_next;
    syn2_reg <= syn2_next;
  end

  logic [3:0] pin_a;
  logic pin_b, pin_ro;
  logic [7:0] pin_c;
  assign pin_a = syn2_reg[3:0];
  assign pin_b = syn2_reg[4];
  assign pin_ro = syn2_reg[5];
  assign pin_c = syn2_reg[13:6];

  // ******************************************************
  // Option byte decode
  // ******************************************************
  ppc_pkg::ppc_clk_src_t src_reg, src_next;
  logic rpin_reg, rpin_next;
  logic [1:0] opt_clk;
  assign opt_clk = option_byte_i[ppc_pkg::OPT_CLK_LSB +: ppc_pkg::OPT_CLK_W];

  // R7 - option byte choice
  always_comb begin
    src_next = src_reg;
    rpin_next = rpin_reg;
    if (!rst_b_i) begin
      // Captured in reset, so the setting is fixed while running
      unique case (opt_clk)
        ppc_pkg::CLK_SRC_XTAL: src_next = ppc_pkg::PPC_SRC_XTAL;
        ppc_pkg::CLK_SRC_EXT: src_next = ppc_pkg::PPC_SRC_EXT;
        default: src_next = ppc_pkg::PPC_SRC_INT;
      endcase
      rpin_next = option_byte_i[ppc_pkg::OPT_RST_PORT_BIT];
    end
  end

  always_ff @(posedge mclk_i) begin
    src_reg <= src_next;
    rpin_reg <= rpin_next;
  end

  // ******************************************************
  // Control registers
  // ******************************************************
  ppc_pkg::ppc_ctrl_t ctl_reg, ctl_next;

  always_comb begin
    ctl_next = ctl_reg;
    if (!rst_b_i) begin
      // R8 - all inputs on reset
      ctl_next.a_dir = ppc_pkg::A_DIR_RST;
      ctl_next.b_dir = ppc_pkg::B_DIR_RST;
      ctl_next.c_dir = ppc_pkg::C_DIR_RST;
      // R17 - latches cleared
      ctl_next.a_data = ppc_pkg::A_DATA_RST;
      ctl_next.b_data = ppc_pkg::B_DATA_RST;
      ctl_next.c_data = ppc_pkg::C_DATA_RST;
      ctl_next.a_pu = ppc_pkg::A_PU_RST;
      ctl_next.b_pu = ppc_pkg::B_PU_RST;
      ctl_next.c_pu = ppc_pkg::C_PU_RST;
    end else begin
      // R2 - per-bit direction
      if (wr_a_dir_i) begin
        ctl_next.a_dir = wdata_i[3:0];
      end
      if (wr_a_pu_i) begin
        ctl_next.a_pu = wdata_i[3:0];
      end
      // R1 - port A latch
      if (wr_a_data_i) begin
        ctl_next.a_data = wdata_i[3:0];
      end
      // R10 - port B controls
      if (wr_b_dir_i) begin
        ctl_next.b_dir = wdata_i[ppc_pkg::B_PIN_BIT];
      end
      if (wr_b_pu_i) begin
        ctl_next.b_pu = wdata_i[ppc_pkg::B_PIN_BIT];
      end
      if (wr_b_data_i) begin
        ctl_next.b_data = wdata_i[ppc_pkg::B_PIN_BIT];
      end
      // R11 - port C controls
      if (wr_c_dir_i) begin
        ctl_next.c_dir = wdata_i;
      end
      if (wr_c_pu_i) begin
        ctl_next.c_pu = wdata_i;
      end
      if (wr_c_data_i) begin
        ctl_next.c_data = wdata_i;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    ctl_reg <= ctl_next;
  end

  // ******************************************************
  // Pad drive and readback
  // ******************************************************
  ppc_pkg::ppc_pad_t pad_reg, pad_next;
  logic [3:0] a_port_ok;
  logic [3:0] a_rd_reg, a_rd_next, a_dir_q, a_pu_q;
  logic [7:0] b_rd_reg, b_rd_next, c_rd_reg, c_rd_next;
  logic osc_reg, osc_next;

  always_comb begin
    a_port_ok = ppc_pkg::A_OK_ALL;
    unique case (src_reg)
      // R4 - internal oscillator, all I/O
      ppc_pkg::PPC_SRC_INT: a_port_ok = ppc_pkg::A_OK_ALL;
      // R5 - crystal takes both
      ppc_pkg::PPC_SRC_XTAL: a_port_ok = ppc_pkg::A_OK_XTAL;
      // R6 - external clock takes upper only
      ppc_pkg::PPC_SRC_EXT: a_port_ok = ppc_pkg::A_OK_EXT;
    endcase
  end

  always_comb begin
    pad_next = '0;
    osc_next = (src_reg == ppc_pkg::PPC_SRC_XTAL);
    // R16 - zero drives the pin
    pad_next.a_oe = ~ctl_next.a_dir & a_port_ok;
    // R19 - driver follows latch next cycle
    pad_next.a_out = ctl_next.a_data & a_port_ok;
    // R13 - timer outputs share pin0 and pin1
    for (int i = 0; i < 2; i++) begin
      if (alt_a_oe_i[i] && a_port_ok[i] && !ctl_next.a_dir[i]) begin
        pad_next.a_out[i] = alt_a_out_i[i];
      end
    end
    // R3 - pull-up only in input and when enabled
    // R18 - no pull-up on outputs
    pad_next.a_pu = ctl_next.a_pu & ctl_next.a_dir & a_port_ok;
    pad_next.b_oe = ~ctl_next.b_dir;
    pad_next.b_out = ctl_next.b_data;
    pad_next.b_pu = ctl_next.b_pu & ctl_next.b_dir;
    pad_next.c_oe = ~ctl_next.c_dir;
    pad_next.c_out = ctl_next.c_data;
    pad_next.c_pu = ctl_next.c_pu & ctl_next.c_dir;
    if (!rst_b_i) begin
      // R9 - pull shared pins low in reset
      pad_next.a_pd[ppc_pkg::A_OSC_OUT_BIT] = 1'h1;
      pad_next.a_pd[ppc_pkg::A_OSC_IN_BIT] = 1'h1;
      osc_next = 1'h0;
    end
  end

  assign a_dir_q = ctl_reg.a_dir;
  assign a_pu_q = ctl_reg.a_pu;

  always_comb begin
    // R15 - pin level in input, latch in output
    a_rd_next = ((a_dir_q & pin_a) | (~a_dir_q & ctl_reg.a_data)) & a_port_ok;
    b_rd_next = 8'h00;
    b_rd_next[ppc_pkg::B_PIN_BIT] = ctl_reg.b_dir ? pin_b : ctl_reg.b_data;
    // R14 - input-only pin valid only as port
    b_rd_next[ppc_pkg::B_RO_BIT] = rpin_reg & pin_ro;
    c_rd_next = (ctl_reg.c_dir & pin_c) | (~ctl_reg.c_dir & ctl_reg.c_data);
  end

  always_ff @(posedge mclk_i) begin
    pad_reg <= pad_next;
    osc_reg <= osc_next;
    a_rd_reg <= a_rd_next;
    b_rd_reg <= b_rd_next;
    c_rd_reg <= c_rd_next;
  end

  // ******************************************************
  // Outputs
  // ******************************************************
  assign port_a_data_o = a_rd_reg;
  assign port_a_direction_o = a_dir_q;
  assign port_a_pullup_enable_o = a_pu_q;
  assign port_b_data_o = b_rd_reg;
  assign port_c_data_o = c_rd_reg;
  assign port_a_out_o = pad_reg.a_out;
  assign port_a_oe_o = pad_reg.a_oe;
  assign port_a_pu_o = pad_reg.a_pu;
  assign port_a_pd_o = pad_reg.a_pd;
  assign port_b_irq_out_o = pad_reg.b_out;
  assign port_b_irq_oe_o = pad_reg.b_oe;
  assign port_b_irq_pu_o = pad_reg.b_pu;
  assign port_c_out_o = pad_reg.c_out;
  assign port_c_oe_o = pad_reg.c_oe;
  assign port_c_pu_o = pad_reg.c_pu;
  assign osc_enable_o = osc_reg;
  assign oscillator_input_pin_o = syn2_reg[ppc_pkg::A_OSC_IN_BIT];
  // R12 - thirteen I/O plus one input-only pin
  assign timer0_capture_input_o = pin_a[0];
  assign timer0_second_input_o = pin_a[1];
  assign external_irq0_o = pin_a[1];
  assign external_irq1_o = pin_b;
  assign reset_pin_is_port_o = rpin_reg;

  // ******************************************************
  // Assertions
  // ******************************************************
  sequence s_a_write;
    wr_a_data_i && rst_b_i;
  endsequence

  a_reset_inputs: assert property (@(posedge mclk_i) !rst_b_i |=> (pad_reg.a_oe == 4'h0) && (pad_reg.c_oe == 8'h00)) // R8
    else $error("port output enabled after reset");
  a_reset_pulldown: assert property (@(posedge mclk_i) !rst_b_i |=> pad_reg.a_pd == 4'hC) // R9
    else $error("shared pins not pulled down in reset");
  a_latch_follow: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      s_a_write ##0 (wdata_i[0] == 1'h1) ##0 !ctl_next.a_dir[0] ##0 !alt_a_oe_i[0] |=> pad_reg.a_out[0]) // R19
    else $error("pin0 driver did not follow latch");
  a_xtal_owns: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      src_reg == ppc_pkg::PPC_SRC_XTAL |=> pad_reg.a_oe[3:2] == 2'h0) // R5
    else $error("crystal pins driven as port");
  a_ext_upper: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      src_reg == ppc_pkg::PPC_SRC_EXT |=> !pad_reg.a_oe[3] && !pad_reg.a_pu[3]) // R6
    else $error("clock input pin used as port");
  a_pu_output: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (pad_reg.c_pu & pad_reg.c_oe) == 8'h00 && (pad_reg.a_pu & pad_reg.a_oe) == 4'h0) // R18
    else $error("pull-up on while driving");
  a_c_readback: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      ##1 ($past(ctl_reg.c_dir) == 8'h00) |-> c_rd_reg == $past(ctl_reg.c_data)) // R15
    else $error("output readback not latch value");
  a_b_dir: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      wr_b_dir_i && !wdata_i[2] |=> pad_reg.b_oe) // R10
    else $error("port B not output after direction write");
  a_int_all_io: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      src_reg == ppc_pkg::PPC_SRC_INT && ctl_next.a_dir == 4'h0 |=> pad_reg.a_oe == 4'hF) // R4
    else $error("internal oscillator pins not usable");

endmodule // ppc_port_pin_control

`default_nettype wire

// ### verif/ppc_board_model.sv
// Board model: resolves every port pad from chip drive, pulls and board levels
`timescale 1ns/10ps
`default_nettype none

module ppc_board_model (
  input wire ppc_pkg::ppc_pad_t pad_i, // Chip pad drive
  input wire logic [3:0] brd_a_i,      // Board level, port A
  input wire logic brd_b_i,            // Board level, irq pin
  input wire logic brd_in_i,           // Board level, input-only pin
  input wire logic [7:0] brd_c_i,      // Board level, port C
  output logic [3:0] a_pins_o,         // Port A wire
  output logic b_pin_o,                // Port B wire
  output logic in_pin_o,               // Input-only wire
  output logic [7:0] c_pins_o          // Port C wire
);
  // ****
  // Wire resolution
  // ****
  // Board lets go of a pin the chip drives; a pull then beats a floating board
  always_comb begin
    a_pins_o = (pad_i.a_oe & pad_i.a_out) | (~pad_i.a_oe & ~pad_i.a_pd & (pad_i.a_pu | brd_a_i));
    b_pin_o = pad_i.b_oe ? pad_i.b_out : (pad_i.b_pu | brd_b_i);
    in_pin_o = brd_in_i;
    c_pins_o = (pad_i.c_oe & pad_i.c_out) | (~pad_i.c_oe & (pad_i.c_pu | brd_c_i));
  end
endmodule // ppc_board_model

`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the port pin control block
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
$display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end

module testbench;
  logic mclk_i = 1'h0;
  logic rst_b_i = 1'h0;
  logic [7:0] option_byte_i = 8'h00;
  logic [8:0] wr = 9'h000;
  logic [7:0] wdata_i = 8'h00;
  logic [1:0] alt_a_oe_i = 2'h0;
  logic [1:0] alt_a_out_i = 2'h0;
  logic [3:0] ba = 4'h0;
  logic bb = 1'h0;
  logic bin = 1'h0;
  logic [7:0] bc = 8'h00;
  logic [3:0] port_a_pins_i, port_a_data_o, port_a_direction_o, port_a_pullup_enable_o;
  logic [3:0] port_a_out_o, port_a_oe_o, port_a_pu_o, port_a_pd_o;
  logic port_b_irq_pin_i, port_b_input_only_pin_i, port_b_irq_out_o, port_b_irq_oe_o, port_b_irq_pu_o;
  logic [7:0] port_c_pins_i, port_b_data_o, port_c_data_o, port_c_out_o, port_c_oe_o, port_c_pu_o;
  logic osc_enable_o, oscillator_input_pin_o, timer0_capture_input_o, timer0_second_input_o;
  logic external_irq0_o, external_irq1_o, reset_pin_is_port_o;
  ppc_pkg::ppc_pad_t pad;
  ppc_pkg::ppc_ctrl_t ctl;
  logic [1:0] src;
  logic rp;
  logic [31:0] r;
  int failures = 0;
  int tests_run = 0;
  int seed = 85818;

  always #10 mclk_i = ~mclk_i;
  assign pad = {port_a_out_o, port_a_oe_o, port_a_pu_o, port_a_pd_o, port_b_irq_out_o, port_b_irq_oe_o,
    port_b_irq_pu_o, port_c_out_o, port_c_oe_o, port_c_pu_o};

  ppc_port_pin_control uut (
    .mclk_i, .rst_b_i, .option_byte_i, .wr_a_dir_i(wr[0]), .wr_a_pu_i(wr[1]), .wr_a_data_i(wr[2]),
    .wr_b_dir_i(wr[3]), .wr_b_pu_i(wr[4]), .wr_b_data_i(wr[5]), .wr_c_dir_i(wr[6]), .wr_c_pu_i(wr[7]),
    .wr_c_data_i(wr[8]), .wdata_i, .port_a_pins_i, .port_b_irq_pin_i, .port_b_input_only_pin_i,
    .port_c_pins_i, .alt_a_oe_i, .alt_a_out_i, .port_a_data_o, .port_a_direction_o, .port_a_pullup_enable_o,
    .port_b_data_o, .port_c_data_o, .port_a_out_o, .port_a_oe_o, .port_a_pu_o, .port_a_pd_o,
    .port_b_irq_out_o, .port_b_irq_oe_o, .port_b_irq_pu_o, .port_c_out_o, .port_c_oe_o, .port_c_pu_o,
    .osc_enable_o, .oscillator_input_pin_o, .timer0_capture_input_o, .timer0_second_input_o,
    .external_irq0_o, .external_irq1_o, .reset_pin_is_port_o
  );

  ppc_board_model board (
    .pad_i(pad), .brd_a_i(ba), .brd_b_i(bb), .brd_in_i(bin), .brd_c_i(bc), .a_pins_o(port_a_pins_i),
    .b_pin_o(port_b_irq_pin_i), .in_pin_o(port_b_input_only_pin_i), .c_pins_o(port_c_pins_i)
  );

  // ****
  // Expectations
  // ****
  // shared pin ownership
  function automatic logic [3:0] usable(input logic [1:0] s);
    return (s == ppc_pkg::CLK_SRC_XTAL) ? 4'h3 : (s == ppc_pkg::CLK_SRC_EXT) ? 4'h7 : 4'hF;
  endfunction

  function automatic ppc_pkg::ppc_pad_t exp_pad(input ppc_pkg::ppc_ctrl_t c, input logic [1:0] s);
    ppc_pkg::ppc_pad_t p;
    p = '0;
    p.a_oe = usable(s) & ~c.a_dir;
    p.a_out = {c.a_data[3:2], (alt_a_oe_i & alt_a_out_i) | (~alt_a_oe_i & c.a_data[1:0])};
    p.a_pu = usable(s) & c.a_dir & c.a_pu;
    p.b_out = c.b_data;
    p.b_oe = ~c.b_dir;
    p.b_pu = c.b_dir & c.b_pu;
    p.c_out = c.c_data;
    p.c_oe = ~c.c_dir;
    p.c_pu = c.c_dir & c.c_pu;
    return p;
  endfunction

  // ****
  // Drivers and checks
  // ****
  // Strobes change only on a rising edge, so callers may come from any time
  task automatic drive(input logic [8:0] s, input logic [7:0] d);
    @(posedge mclk_i);
    wr <= s;
    wdata_i <= d;
    @(posedge mclk_i);
    wr <= 9'h000;
    if (s[0]) ctl.a_dir = d[3:0];
    if (s[1]) ctl.a_pu = d[3:0];
    if (s[2]) ctl.a_data = d[3:0];
    if (s[3]) ctl.b_dir = d[2];
    if (s[4]) ctl.b_pu = d[2];
    if (s[5]) ctl.b_data = d[2];
    if (s[6]) ctl.c_dir = d;
    if (s[7]) ctl.c_pu = d;
    if (s[8]) ctl.c_data = d;
  endtask

  task automatic check_all();
    ppc_pkg::ppc_pad_t e;
    logic [3:0] wa;
    logic wb;
    logic [7:0] wc;
    e = exp_pad(ctl, src);
    wa = (e.a_oe & e.a_out) | (~e.a_oe & (e.a_pu | ba));
    wb = e.b_oe ? e.b_out : (e.b_pu | bb);
    wc = (e.c_oe & e.c_out) | (~e.c_oe & (e.c_pu | bc));
    `CHK(port_a_oe_o, e.a_oe)
    `CHK(port_a_out_o & e.a_oe, e.a_out & e.a_oe)
    `CHK(port_a_pu_o, e.a_pu)
    `CHK(port_a_pd_o, 4'h0)
    `CHK({port_a_direction_o, port_a_pullup_enable_o}, {ctl.a_dir, ctl.a_pu})
    `CHK(port_a_data_o, usable(src) & ((ctl.a_dir & wa) | (~ctl.a_dir & ctl.a_data)))
    `CHK(osc_enable_o, src == ppc_pkg::CLK_SRC_XTAL)
    `CHK({oscillator_input_pin_o, timer0_capture_input_o}, {wa[3], wa[0]})
    `CHK({timer0_second_input_o, external_irq0_o}, {wa[1], wa[1]})
    `CHK({port_b_irq_oe_o, port_b_irq_pu_o, port_b_irq_out_o & e.b_oe}, {e.b_oe, e.b_pu, e.b_out & e.b_oe})
    `CHK(external_irq1_o, wb)
    `CHK(port_b_data_o, {3'h0, rp & bin, 1'h0, ctl.b_dir ? wb : ctl.b_data, 2'h0})
    `CHK({port_c_oe_o, port_c_pu_o, port_c_out_o & e.c_oe}, {e.c_oe, e.c_pu, e.c_out & e.c_oe})
    `CHK(port_c_data_o, (ctl.c_dir & wc) | (~ctl.c_dir & ctl.c_data))
    `CHK(reset_pin_is_port_o, rp)
  endtask

  task automatic do_reset(input logic [7:0] opt);
    rst_b_i <= 1'h0;
    option_byte_i <= opt;
    repeat (3) @(posedge mclk_i);
    rst_b_i <= 1'h1;
    #1;
    `CHK({port_a_oe_o, port_a_pu_o, port_a_out_o, port_a_direction_o}, {12'h000, ppc_pkg::A_DIR_RST})
    `CHK(port_a_pd_o, 4'hC)
    `CHK({port_c_oe_o, port_b_irq_oe_o, osc_enable_o}, 10'h000)
    ctl = {ppc_pkg::A_DIR_RST, ppc_pkg::A_PU_RST, ppc_pkg::A_DATA_RST, 3'h4, ppc_pkg::C_DIR_RST,
      ppc_pkg::C_PU_RST, ppc_pkg::C_DATA_RST};
    src = (opt[1:0] == 2'h3) ? ppc_pkg::CLK_SRC_INT : opt[1:0];
    rp = opt[2];
  endtask

  // Option byte keeps changing after release; the captured source must not follow it
  task automatic rand_step();
    @(posedge mclk_i);
    r = $random(seed);
    ba <= r[3:0];
    bb <= r[4];
    bin <= r[5];
    bc <= r[13:6];
    alt_a_oe_i <= r[15:14];
    alt_a_out_i <= r[17:16];
    option_byte_i <= r[25:18];
    r = $random(seed);
    drive(r[8:0], r[31:24]);
    repeat (4) @(posedge mclk_i);
    #1;
    check_all();
  endtask

  task automatic conclude();
    if (failures == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    do_reset(8'h00);
    drive(9'h001, 8'h00);
    #1;
    drive(9'h004, 8'h05);
    #1;
    `CHK(port_a_out_o, 4'h5)
    drive(9'h004, 8'h0A);
    #1;
    `CHK(port_a_out_o, 4'hA)
    repeat (3) @(posedge mclk_i);
    #1;
    `CHK(port_a_data_o, 4'hA)
    for (int k = 0; k < 8; k++) begin
      @(posedge mclk_i);
      do_reset({5'h00, k[2:0]});
      drive(9'h041, 8'h00);
      repeat (4) @(posedge mclk_i);
      #1;
      `CHK({port_a_data_o, port_c_data_o}, 12'h000)
      repeat (12) rand_step();
    end
    conclude();
  end

  initial begin
    #200000;
    failures++;
    conclude();
  end
endmodule // testbench

`default_nettype wire
